// ### verilog/cfg_port_pkg.sv
// shared constants for the serial configuration port and its host
package cfg_port_pkg;
	localparam logic [6:0] SLAVE_ADDR = 7'h56;
	localparam logic [7:0] ADDR_WRITE_BYTE = 8'hAC;
	localparam logic [7:0] ADDR_READ_BYTE = 8'hAD;
	localparam logic [7:0] REG_DETECT_STATUS = 8'h00;
	localparam logic [7:0] REG_CHAN_STATUS_A = 8'h01;
	localparam logic [7:0] REG_CHAN_STATUS_B = 8'h02;
	localparam logic [7:0] REG_CLK_LANE0 = 8'h03;
	localparam logic [7:0] REG_LANE1_LANE2 = 8'h04;
	localparam logic [7:0] REG_ON_THRESH = 8'h05;
	localparam logic [7:0] REG_OFF_THRESH = 8'h06;
	localparam logic [7:0] REG_EN_SOURCE = 8'h07;
	localparam logic [7:0] REG_OUT_AMP = 8'h08;
	localparam logic [7:0] RST_CLK_LANE0 = 8'h77;
	localparam logic [7:0] RST_LANE1_LANE2 = 8'h77;
	localparam logic [7:0] RST_ON_THRESH = 8'h00;
	localparam logic [7:0] RST_OFF_THRESH = 8'h00;
	localparam logic [7:0] RST_EN_SOURCE = 8'h00;
	localparam logic [7:0] RST_OUT_AMP = 8'h78;
	// field positions
	localparam int EN_HI_BIT = 7;
	localparam int BOOST_HI_LSB = 4;
	localparam int EN_LO_BIT = 3;
	localparam int BOOST_LO_LSB = 0;
	localparam int THRESH_LSB = 0;
	localparam int AMP_LSB = 2;
	localparam int SRC_BIT = 0;
	localparam int REV_LSB = 4;
	// timing: bus free time and longest clock-high, in ns
	localparam int BUS_FREE_NS = 4700;
	localparam int HIGH_MAX_NS = 50000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int BUS_FREE_CYC = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HIGH_MAX_CYC = HIGH_MAX_NS / CLK_PERIOD_NS;
	// host bit timing: half period of the serial clock, in ns
	localparam int HALF_BIT_NS = 5000;
	localparam int HALF_BIT_CYC = HALF_BIT_NS / CLK_PERIOD_NS;
endpackage

// ### verilog/cfg_port_if.sv
// serial bus wires between host and configuration port
`timescale 1ns/1ps
interface cfg_port_if;
	logic chip_select;
	logic serial_bus_clock;
	logic sda_host_out;
	logic sda_host_oe;
	logic sda_dev_out;
	logic sda_dev_oe;
	logic sda;
	// open drain: low wins, pulled high otherwise
	assign sda = !((sda_host_oe && !sda_host_out) || (sda_dev_oe && !sda_dev_out));
	modport host (output chip_select, output serial_bus_clock,
		output sda_host_out, output sda_host_oe, input sda);
	modport device (input chip_select, input serial_bus_clock,
		output sda_dev_out, output sda_dev_oe, input sda);
endinterface // cfg_port_if

// ### verilog/pin_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_r <= INIT;
			sync_out <= INIT;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule // pin_sync

// ### verilog/cfg_port_device.sv
// configuration port slave with chip select and register file
// Notes on behaviour
// - respond only while chip select high
// - host drops select for other slaves
// - port stays alive in standby
// - decode only address 1010110
// - write address byte is AC hex
// - data changes only while clock low
// - start is data falling, clock high
// - stop is data rising, clock high
// - idle after free time or long high
// - write is start,address,index,data,stop
// - acknowledge address, index, each data byte
// - read uses index write then restart
// - shift register contents out, msb first
// - host nacks read byte, then stop
// - select brackets each transaction
// - read-only ignores writes, read-write stores
// - enable source picks pin or bit
// - boost source pin picks boost codes
// - detect bit follows on/off thresholds
// - bus free time at least 4.7 us
`timescale 1ns/1ps
module cfg_port_device
	import cfg_port_pkg::*;
#(
	parameter int FREE_CYC = BUS_FREE_CYC,
	parameter int HIGHMAX_CYC = HIGH_MAX_CYC,
	parameter logic [3:0] REVISION_ID = 4'h5 // arbitrary value
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// serial bus
	cfg_port_if.device bus,
	// analog-side pins and status
	input wire logic enable_pin,
	input wire logic boost_source_select,
	input wire logic [2:0] boost_pins,
	input wire logic signal_detect_raw,
	// settings driven to the channels
	output logic [2:0] channel_boost_code0,
	output logic [2:0] channel_boost_code1,
	output logic [2:0] channel_boost_code2,
	output logic [3:0] lane_enable_n,
	output logic [1:0] detect_on_threshold,
	output logic [1:0] detect_off_threshold,
	output logic [1:0] output_level,
	output logic device_active,
	output logic signal_detect,
	output logic bus_idle
);
	initial begin
		if (FREE_CYC < 1 || HIGHMAX_CYC < FREE_CYC)
			$error("cfg_port_device: bad timing parameters");
	end

	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_ADDR = 6'b000010,
		ST_INDEX = 6'b000100,
		ST_WDATA = 6'b001000,
		ST_RDATA = 6'b010000,
		ST_IGNORE = 6'b100000
	} slave_state_t;

	localparam int CW = $clog2(HIGHMAX_CYC + 1);

	logic cs_s, scl_s, sda_s, en_s, fsel_s, sd_s;
	logic [2:0] bst_s;
	pin_sync #(.WIDTH(3), .INIT(3'h7)) u_sync_bus (
		.core_clk(core_clk), .sys_rst(sys_rst),
		.async_in({bus.chip_select, bus.serial_bus_clock, bus.sda}),
		.sync_out({cs_s, scl_s, sda_s}));
	pin_sync #(.WIDTH(6), .INIT(6'h00)) u_sync_pins (
		.core_clk(core_clk), .sys_rst(sys_rst),
		.async_in({enable_pin, boost_source_select, boost_pins,
			signal_detect_raw}),
		.sync_out({en_s, fsel_s, bst_s, sd_s}));

	logic scl_d_r, sda_d_r;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end
	wire start_ev = cs_s && scl_s && scl_d_r && sda_d_r && !sda_s;
	wire stop_ev = cs_s && scl_s && scl_d_r && !sda_d_r && sda_s;
	wire scl_rise = scl_s && !scl_d_r;
	wire scl_fall = !scl_s && scl_d_r;

	// idle timers: both lines high since stop, or high too long
	logic [CW-1:0] high_cnt_r;
	logic stopped_r;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			high_cnt_r <= '0;
			stopped_r <= 1'b0;
			bus_idle <= 1'b1;
		end else begin
			if (!(scl_s && sda_s))
				high_cnt_r <= '0;
			else if (high_cnt_r != CW'(HIGHMAX_CYC))
				high_cnt_r <= high_cnt_r + 1'b1;
			if (stop_ev)
				stopped_r <= 1'b1;
			else if (start_ev)
				stopped_r <= 1'b0;
			if (start_ev)
				bus_idle <= 1'b0;
			else if (scl_s && sda_s && ((stopped_r &&
				high_cnt_r >= CW'(FREE_CYC)) ||
				high_cnt_r >= CW'(HIGHMAX_CYC)))
				bus_idle <= 1'b1;
		end
	end

	slave_state_t state_r;
	logic [7:0] shift_r, index_r;
	logic [3:0] bit_cnt_r;
	logic ack_phase_r, reading_r;
	logic [7:0] reg03_r, reg04_r, reg05_r, reg06_r, reg07_r, reg08_r;
	logic [7:0] rd_val;
	logic wr_stb;

	always_comb begin
		case (index_r)
			REG_DETECT_STATUS: rd_val = {REVISION_ID, 3'h0, signal_detect};
			REG_CHAN_STATUS_A: rd_val = {1'b0, channel_boost_code0,
				lane_enable_n[0], 3'h0};
			REG_CHAN_STATUS_B: rd_val = {1'b0, channel_boost_code2,
				1'b0, channel_boost_code1};
			REG_CLK_LANE0: rd_val = reg03_r;
			REG_LANE1_LANE2: rd_val = reg04_r;
			REG_ON_THRESH: rd_val = reg05_r;
			REG_OFF_THRESH: rd_val = reg06_r;
			REG_EN_SOURCE: rd_val = reg07_r;
			REG_OUT_AMP: rd_val = reg08_r;
			default: rd_val = 8'h00;
		endcase
	end

	// byte engine; sampled on clock rise, drives on clock fall
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
			shift_r <= '0;
			index_r <= '0;
			bit_cnt_r <= '0;
			ack_phase_r <= 1'b0;
			reading_r <= 1'b0;
			bus.sda_dev_out <= 1'b1;
			bus.sda_dev_oe <= 1'b0;
			wr_stb <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			if (!cs_s || stop_ev) begin
				state_r <= ST_IDLE;
				bus.sda_dev_oe <= 1'b0;
			end else if (start_ev) begin // repeated start too
				state_r <= ST_ADDR;
				bit_cnt_r <= '0;
				ack_phase_r <= 1'b0;
				bus.sda_dev_oe <= 1'b0;
			end else if (scl_rise && !ack_phase_r &&
				state_r != ST_RDATA && state_r != ST_IDLE) begin
				shift_r <= {shift_r[6:0], sda_s};
				bit_cnt_r <= bit_cnt_r + 1'b1;
			end else if (scl_rise && ack_phase_r && state_r == ST_RDATA) begin
				if (sda_s)
					state_r <= ST_IGNORE; // nack ends read
			end else if (scl_fall) begin
				if (state_r == ST_RDATA && !ack_phase_r) begin
					if (bit_cnt_r == 4'd8) begin
						bus.sda_dev_oe <= 1'b0;
						ack_phase_r <= 1'b1;
						bit_cnt_r <= '0;
					end else begin
						// msb first
						bus.sda_dev_out <= shift_r[7];
						bus.sda_dev_oe <= !shift_r[7];
						shift_r <= {shift_r[6:0], 1'b0};
						bit_cnt_r <= bit_cnt_r + 1'b1;
					end
				end else if (ack_phase_r) begin
					ack_phase_r <= 1'b0;
					bus.sda_dev_oe <= 1'b0;
					if (state_r == ST_RDATA) begin
						// bit 7 goes out now, so keep only the rest
						shift_r <= {rd_val[6:0], 1'b0};
						bus.sda_dev_out <= rd_val[7];
						bus.sda_dev_oe <= !rd_val[7];
						bit_cnt_r <= 4'd1;
					end
				end else if (bit_cnt_r == 4'd8) begin
					bit_cnt_r <= '0;
					case (state_r)
						ST_ADDR: begin
							if (shift_r[7:1] == SLAVE_ADDR) begin
								ack_phase_r <= 1'b1;
								bus.sda_dev_out <= 1'b0;
								bus.sda_dev_oe <= 1'b1;
								reading_r <= shift_r[0];
								state_r <= shift_r[0] ? ST_RDATA : ST_INDEX;
							end else
								state_r <= ST_IGNORE;
						end
						ST_INDEX: begin
							index_r <= shift_r;
							ack_phase_r <= 1'b1;
							bus.sda_dev_out <= 1'b0;
							bus.sda_dev_oe <= 1'b1;
							state_r <= ST_WDATA;
						end
						ST_WDATA: begin
							wr_stb <= 1'b1;
							ack_phase_r <= 1'b1;
							bus.sda_dev_out <= 1'b0;
							bus.sda_dev_oe <= 1'b1;
							index_r <= index_r + 8'h01;
						end
						default: state_r <= ST_IGNORE;
					endcase
				end
			end
		end
	end

	// register file; held in core_clk domain, alive in standby
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg03_r <= RST_CLK_LANE0;
			reg04_r <= RST_LANE1_LANE2;
			reg05_r <= RST_ON_THRESH;
			reg06_r <= RST_OFF_THRESH;
			reg07_r <= RST_EN_SOURCE;
			reg08_r <= RST_OUT_AMP;
		end else if (wr_stb) begin
			// read-only offsets fall through untouched
			case (index_r - 8'h01)
				REG_CLK_LANE0: reg03_r <= shift_r;
				REG_LANE1_LANE2: reg04_r <= shift_r;
				REG_ON_THRESH: reg05_r <= shift_r;
				REG_OFF_THRESH: reg06_r <= shift_r;
				REG_EN_SOURCE: reg07_r <= shift_r;
				REG_OUT_AMP: reg08_r <= shift_r;
				default: ;
			endcase
		end
	end

	// channel outputs
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			channel_boost_code0 <= '0;
			channel_boost_code1 <= '0;
			channel_boost_code2 <= '0;
			lane_enable_n <= 4'hF;
			detect_on_threshold <= '0;
			detect_off_threshold <= '0;
			output_level <= '0;
			device_active <= 1'b0;
			signal_detect <= 1'b0;
		end else begin
			if (fsel_s) begin
				channel_boost_code0 <= bst_s;
				channel_boost_code1 <= bst_s;
				channel_boost_code2 <= bst_s;
			end else begin
				channel_boost_code0 <= reg03_r[BOOST_HI_LSB +: 3];
				channel_boost_code1 <= reg04_r[BOOST_LO_LSB +: 3];
				channel_boost_code2 <= reg04_r[BOOST_HI_LSB +: 3];
			end
			lane_enable_n <= {reg04_r[EN_HI_BIT], reg04_r[EN_LO_BIT],
				reg03_r[EN_HI_BIT], reg03_r[EN_LO_BIT]};
			detect_on_threshold <= reg05_r[THRESH_LSB +: 2];
			detect_off_threshold <= reg06_r[THRESH_LSB +: 2];
			output_level <= reg08_r[AMP_LSB +: 2];
			device_active <= reg07_r[SRC_BIT] ? !reg03_r[EN_LO_BIT] : en_s;
			signal_detect <= sd_s; // analog hysteresis sets sd_s
		end
	end
endmodule // cfg_port_device

// ### verilog/cfg_port_host.sv
// host bus master: single register write or read with chip select
`timescale 1ns/1ps
module cfg_port_host
	import cfg_port_pkg::*;
#(
	parameter int HALF_CYC = HALF_BIT_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// serial bus
	cfg_port_if.host bus,
	// user request
	input wire logic req_valid,
	input wire logic req_read,
	input wire logic [7:0] req_index,
	input wire logic [7:0] req_wdata,
	// answer
	output logic busy,
	output logic done,
	output logic nack_err,
	output logic [7:0] rdata
);
	initial begin
		if (HALF_CYC < 2)
			$error("cfg_port_host: HALF_CYC too small");
	end
	localparam int HW = $clog2(HALF_CYC + 1);
	logic sda_s;
	pin_sync #(.WIDTH(1), .INIT(1'b1)) u_sync (
		.core_clk(core_clk), .sys_rst(sys_rst),
		.async_in(bus.sda), .sync_out(sda_s));

	// micro-steps: each step is one half bit; byte_no and cur_byte hold the byte plan
	logic [HW-1:0] tick_r;
	logic [6:0] step_r;
	logic [7:0] idx_r, wd_r;
	logic rd_r;
	wire tick = (tick_r == HW'(HALF_CYC - 1));
	// byte k (0..3) covers steps 4+18k .. 21+18k, or 8+18k .. 25+18k for read bytes 2 and 3; two halves per bit
	logic [7:0] cur_byte;
	logic [1:0] byte_no;
	logic [4:0] in_byte;
	logic [6:0] adj_step;
	always_comb begin
		// restart steals four half bits ahead of the read address
		adj_step = (rd_r && step_r >= 7'd44) ? step_r - 7'd8 : step_r - 7'd4;
		byte_no = 2'(adj_step / 7'd18);
		in_byte = 5'(adj_step % 7'd18);
		case (byte_no)
			2'd0: cur_byte = ADDR_WRITE_BYTE;
			2'd1: cur_byte = idx_r;
			2'd2: cur_byte = rd_r ? ADDR_READ_BYTE : wd_r;
			default: cur_byte = 8'hFF;
		endcase
	end
	wire [6:0] last_step = rd_r ? 7'd83 : 7'd63;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tick_r <= '0;
			step_r <= '0;
			idx_r <= '0;
			wd_r <= '0;
			rd_r <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			nack_err <= 1'b0;
			rdata <= '0;
			bus.chip_select <= 1'b0;
			bus.serial_bus_clock <= 1'b1;
			bus.sda_host_out <= 1'b1;
			bus.sda_host_oe <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy) begin
				if (req_valid) begin
					busy <= 1'b1;
					idx_r <= req_index;
					wd_r <= req_wdata;
					rd_r <= req_read;
					nack_err <= 1'b0;
					step_r <= '0;
					tick_r <= '0;
					bus.chip_select <= 1'b1; // select before start
				end
			end else if (!tick)
				tick_r <= tick_r + 1'b1;
			else begin
				tick_r <= '0;
				step_r <= step_r + 7'd1;
				if (step_r == 7'd2) begin
					bus.sda_host_oe <= 1'b1; // start
					bus.sda_host_out <= 1'b0;
				end else if (step_r == 7'd3)
					bus.serial_bus_clock <= 1'b0;
				else if (step_r >= 7'd4 && step_r < last_step - 7'd3) begin
					// restart between index and read address
					if (rd_r && byte_no == 2'd2 && step_r < 7'd44) begin
						case (step_r)
							7'd40: begin
								// clock low first so the slave drops its ack
								bus.serial_bus_clock <= 1'b0;
								bus.sda_host_oe <= 1'b0;
							end
							7'd41: bus.serial_bus_clock <= 1'b1;
							7'd42: begin
								bus.sda_host_oe <= 1'b1;
								bus.sda_host_out <= 1'b0;
							end
							default: bus.serial_bus_clock <= 1'b0;
						endcase
					end else if (!in_byte[0]) begin
						// low half: set data, clock low
						bus.serial_bus_clock <= 1'b0;
						if (in_byte < 5'd16) begin
							if (rd_r && byte_no == 2'd3) begin
								bus.sda_host_oe <= 1'b0;
							end else begin
								bus.sda_host_out <= cur_byte[3'(7 - in_byte[4:1])];
								bus.sda_host_oe <= !cur_byte[3'(7 - in_byte[4:1])];
							end
						end else begin
							// ninth bit: release, or nack after read
							bus.sda_host_oe <= 1'b0;
						end
					end else begin
						bus.serial_bus_clock <= 1'b1;
						if (in_byte == 5'd17 && !(rd_r && byte_no == 2'd3) && sda_s)
							nack_err <= 1'b1;
						if (in_byte < 5'd16 && rd_r && byte_no == 2'd3)
							rdata <= {rdata[6:0], sda_s};
					end
				end else if (step_r == last_step - 7'd3) begin
					bus.serial_bus_clock <= 1'b0;
					bus.sda_host_oe <= 1'b1;
					bus.sda_host_out <= 1'b0;
				end else if (step_r == last_step - 7'd2)
					bus.serial_bus_clock <= 1'b1;
				else if (step_r == last_step - 7'd1)
					bus.sda_host_oe <= 1'b0; // stop
				else if (step_r == last_step) begin
					bus.chip_select <= 1'b0;
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule // cfg_port_host

// ### bench/cfg_port_properties.sv
// bus-level assertions between host and configuration port
`timescale 1ns/1ps
module cfg_port_properties
	import cfg_port_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// bus wires
	input wire logic chip_select,
	input wire logic serial_bus_clock,
	input wire logic sda_host_out,
	input wire logic sda_host_oe,
	input wire logic sda_dev_out,
	input wire logic sda_dev_oe,
	input wire logic sda
);
	logic scl_q_r;
	logic sda_q_r;
	logic rd_r;
	logic [4:0] cnt_r;
	logic [7:0] sh_r;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic dev_low;
	assign scl_rise = serial_bus_clock && !scl_q_r;
	assign scl_fall = !serial_bus_clock && scl_q_r;
	assign start_ev = serial_bus_clock && scl_q_r && sda_q_r && !sda;
	assign dev_low = sda_dev_oe && !sda_dev_out;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_q_r <= serial_bus_clock;
			sda_q_r <= sda;
		end
	end
	// clock rises since the last start, saturating
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			cnt_r <= 5'h00;
		else if (start_ev)
			cnt_r <= 5'h00;
		else if (scl_rise && cnt_r != 5'h1F)
			cnt_r <= cnt_r + 5'h01;
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sh_r <= 8'h00;
			rd_r <= 1'b0;
		end else if (scl_rise) begin
			sh_r <= {sh_r[6:0], sda};
			if (cnt_r == 5'h07)
				rd_r <= sda;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	property p_cs_quiet;
		!chip_select [*4] |-> !sda_dev_oe;
	endproperty
	a_cs_quiet: assert property (p_cs_quiet)
		else $error("device drives data while deselected");
	property p_dev_stable;
		serial_bus_clock && scl_q_r |-> $stable(dev_low);
	endproperty
	a_dev_stable: assert property (p_dev_stable)
		else $error("device changed data while clock high");
	property p_addr_byte;
		scl_rise && cnt_r == 5'h08 |-> sh_r[7:1] == SLAVE_ADDR;
	endproperty
	a_addr_byte: assert property (p_addr_byte)
		else $error("address byte does not carry the slave address");
	property p_addr_ack;
		scl_rise && cnt_r == 5'h08 |-> !sda;
	endproperty
	a_addr_ack: assert property (p_addr_ack)
		else $error("address byte not acknowledged");
	property p_index_ack;
		scl_rise && cnt_r == 5'h11 && !rd_r |-> !sda;
	endproperty
	a_index_ack: assert property (p_index_ack)
		else $error("index byte not acknowledged");
	property p_data_ack;
		scl_rise && cnt_r == 5'h1A && !rd_r |-> !sda;
	endproperty
	a_data_ack: assert property (p_data_ack)
		else $error("data byte not acknowledged");
	property p_read_release;
		scl_rise && cnt_r == 5'h11 && rd_r |-> !dev_low;
	endproperty
	a_read_release: assert property (p_read_release)
		else $error("device holds data during host nack");
	property p_ack_release;
		scl_fall && cnt_r == 5'h1B && !rd_r |-> ##[1:6] !dev_low;
	endproperty
	a_ack_release: assert property (p_ack_release)
		else $error("device kept acknowledge past its bit");
	c_write: cover property (scl_rise && cnt_r == 5'h1A && !rd_r);
	c_read: cover property (scl_rise && cnt_r == 5'h11 && rd_r);
	c_select: cover property (!chip_select ##1 chip_select);
endmodule // cfg_port_properties

// ### bench/testbench.sv
// self-checking bench: host and configuration port on one bus
`timescale 1ns/1ps
module testbench
	import cfg_port_pkg::*;
;
	localparam logic [3:0] REV = 4'h9; // arbitrary value
	localparam logic [7:0] RST_TAB [3:8] = '{RST_CLK_LANE0, RST_LANE1_LANE2,
		RST_ON_THRESH, RST_OFF_THRESH, RST_EN_SOURCE, RST_OUT_AMP};
	logic core_clk;
	logic sys_rst;
	logic enable_pin, boost_source_select, signal_detect_raw;
	logic [2:0] boost_pins;
	logic req_valid, req_read, busy, done, nack_err;
	logic [7:0] req_index, req_wdata, rdata;
	logic [2:0] channel_boost_code0, channel_boost_code1, channel_boost_code2;
	logic [3:0] lane_enable_n;
	logic [1:0] detect_on_threshold, detect_off_threshold, output_level;
	logic device_active, signal_detect, bus_idle;
	int miscompares = 0;
	int check_count = 0;
	cfg_port_if bus_if();
	cfg_port_host #(.HALF_CYC(8)) i_cfg_port_host (.core_clk(core_clk),
		.sys_rst(sys_rst), .bus(bus_if.host), .req_valid(req_valid),
		.req_read(req_read), .req_index(req_index), .req_wdata(req_wdata),
		.busy(busy), .done(done), .nack_err(nack_err), .rdata(rdata));
	cfg_port_device #(.FREE_CYC(10), .HIGHMAX_CYC(40), .REVISION_ID(REV))
		i_cfg_port_device (.core_clk(core_clk), .sys_rst(sys_rst),
		.bus(bus_if.device), .enable_pin(enable_pin),
		.boost_source_select(boost_source_select), .boost_pins(boost_pins),
		.signal_detect_raw(signal_detect_raw),
		.channel_boost_code0(channel_boost_code0),
		.channel_boost_code1(channel_boost_code1),
		.channel_boost_code2(channel_boost_code2),
		.lane_enable_n(lane_enable_n), .detect_on_threshold(detect_on_threshold),
		.detect_off_threshold(detect_off_threshold), .output_level(output_level),
		.device_active(device_active), .signal_detect(signal_detect),
		.bus_idle(bus_idle));
	cfg_port_properties i_cfg_port_properties (.core_clk(core_clk),
		.sys_rst(sys_rst), .chip_select(bus_if.chip_select),
		.serial_bus_clock(bus_if.serial_bus_clock),
		.sda_host_out(bus_if.sda_host_out), .sda_host_oe(bus_if.sda_host_oe),
		.sda_dev_out(bus_if.sda_dev_out), .sda_dev_oe(bus_if.sda_dev_oe),
		.sda(bus_if.sda));
	task automatic stop_test;
		$display("checks=%0d miscompares=%0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic op(input logic rd, input logic [7:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		req_valid <= 1'b1;
		req_read <= rd;
		req_index <= idx;
		req_wdata <= d;
		@(posedge core_clk);
		req_valid <= 1'b0;
		while (done !== 1'b1 && n < 3000) begin
			@(negedge core_clk);
			n++;
		end
		chk({7'h0, done}, 8'h01);
		chk({7'h0, nack_err}, 8'h00);
		// leave the bus free before the next start
		repeat (12) @(posedge core_clk);
	endtask
	task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
		op(1'b0, idx, d);
	endtask
	task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp);
		op(1'b1, idx, 8'h00);
		chk(rdata, exp);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	initial begin
		#400000;
		miscompares++;
		stop_test();
	end
	initial begin
		sys_rst = 1'b1;
		enable_pin = 1'b0;
		boost_source_select = 1'b0;
		boost_pins = 3'h0;
		signal_detect_raw = 1'b0;
		req_valid = 1'b0;
		req_read = 1'b0;
		req_index = 8'h00;
		req_wdata = 8'h00;
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		for (int i = 3; i <= 8; i++) begin
			reg_rd(8'(i), RST_TAB[i]);
		end
		reg_rd(REG_DETECT_STATUS, {REV, 4'h0});
		reg_wr(REG_DETECT_STATUS, 8'hFF);
		reg_rd(REG_DETECT_STATUS, {REV, 4'h0});
		signal_detect_raw <= 1'b1;
		repeat (6) @(posedge core_clk);
		chk({7'h0, signal_detect}, 8'h01);
		reg_rd(REG_DETECT_STATUS, {REV, 4'h1});
		reg_wr(REG_LANE1_LANE2, 8'hA5);
		reg_rd(REG_LANE1_LANE2, 8'hA5);
		reg_rd(REG_CHAN_STATUS_B, 8'h25);
		chk({5'h0, channel_boost_code1}, 8'h05);
		chk({5'h0, channel_boost_code2}, 8'h02);
		reg_wr(REG_CLK_LANE0, 8'h38);
		reg_rd(REG_CHAN_STATUS_A, 8'h38);
		chk({5'h0, channel_boost_code0}, 8'h03);
		chk({4'h0, lane_enable_n}, 8'h09);
		chk({7'h0, device_active}, 8'h00);
		enable_pin <= 1'b1;
		repeat (6) @(posedge core_clk);
		chk({7'h0, device_active}, 8'h01);
		reg_wr(REG_EN_SOURCE, 8'h01);
		chk({7'h0, device_active}, 8'h00);
		reg_wr(REG_CLK_LANE0, 8'h30);
		enable_pin <= 1'b0;
		repeat (6) @(posedge core_clk);
		chk({7'h0, device_active}, 8'h01);
		reg_wr(REG_ON_THRESH, 8'h02);
		reg_wr(REG_OFF_THRESH, 8'h03);
		reg_wr(REG_OUT_AMP, 8'h04);
		chk({6'h0, detect_on_threshold}, 8'h02);
		chk({6'h0, detect_off_threshold}, 8'h03);
		chk({6'h0, output_level}, 8'h01);
		reg_rd(REG_OFF_THRESH, 8'h03);
		reg_rd(REG_OUT_AMP, 8'h04);
		chk({7'h0, bus_idle}, 8'h01);
		boost_source_select <= 1'b1;
		boost_pins <= 3'h6;
		repeat (6) @(posedge core_clk);
		chk({5'h0, channel_boost_code0}, 8'h06);
		chk({5'h0, channel_boost_code1}, 8'h06);
		chk({5'h0, channel_boost_code2}, 8'h06);
		stop_test();
	end
endmodule // testbench
